/* File: hdl/dcc_consts.svh */
// Purpose: Offsets, field positions, reset values and counts of the core control block
// Assumes: Control port addresses are 16-bit word addresses
// Notes:   Included by the package, the property module, the bench and the host model
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

`define DCC_ADDR_IF_FIRST     16'h0800
`define DCC_ADDR_IF_LAST      16'h0807
`define DCC_ADDR_GPIO_SET     16'h0808
`define DCC_ADDR_AUX_FIRST    16'h0809
`define DCC_ADDR_AUX_LAST     16'h080C
`define DCC_ADDR_SL_DATA0     16'h0810
`define DCC_ADDR_SL_DATA4     16'h0814
`define DCC_ADDR_SL_ADDR0     16'h0815
`define DCC_ADDR_SL_ADDR4     16'h0819
`define DCC_ADDR_CORE_CTRL    16'h081C

`define DCC_CTRL_RESET        16'h0000
`define DCC_CTRL_WR_MASK      16'h31FF
`define DCC_BIT_TRIGGER       5

`define DCC_IF_COUNT          8
`define DCC_AUX_COUNT         4
`define DCC_SL_COUNT          5
`define DCC_SL_LAST_IDX       3'h4

`define DCC_IPS_1X            11'h400
`define DCC_IPS_2X            11'h200
`define DCC_IPS_4X            11'h100

`endif

/* File: hdl/dcc_core_ctrl.sv */
// Purpose: Core control word, host write overrides, safeload engine and rate decode
// Assumes: Control port strobes are synchronous single-cycle pulses
// Notes:   Read data returns one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none

// How it works
// - With the aux override set, host writes to the four aux ADC data words are stored.
// - With the aux override set, the aux ADC words stop following the pin samples.
// - With the GPIO override set, the GPIO setting word takes host writes, not pin levels.
// - With the interface override set, DSP program writes to interface words are dropped.
// - Writing one to the trigger bit starts copying pending safeload pairs to parameter RAM.
// - The trigger bit clears itself when the copy has finished, unless a trigger write lands in the last copy cycle.
// - Five address/data pairs exist and only pairs written since the last copy are sent.
// - The ADC unmute bit resets to zero and mutes the ADC output while zero.
// - The DAC unmute bit resets to zero and mutes the DAC outputs while zero.
// - The core clear bit resets to zero and holds the DSP registers cleared while zero.
// - The rate field picks 1024, 512 or 256 instructions per sample, code three reserved.
// - The quadruple rate setting runs the converters at 192 kHz.
module dcc_core_ctrl
  import dcc_pkg::*;
(
  // Clock and reset
  input  wire  logic        clk,
  input  wire  logic        resetn,
  // Control port
  input  wire  logic        cp_wr,
  input  wire  logic        cp_rd,
  input  wire  logic [15:0] cp_addr,
  input  wire  logic [15:0] cp_wdata,
  output var   logic [15:0] cp_rdata,
  output var   logic        cp_rd_valid,
  // DSP program writes to interface words
  input  wire  logic        dsp_if_wr,
  input  wire  logic [2:0]  dsp_if_idx,
  input  wire  logic [15:0] dsp_if_data,
  // Pin samples
  input  wire  logic [15:0] gpio_pins,
  input  wire  logic [63:0] aux_adc_samples,
  // Parameter RAM write
  output var   logic        pram_wr_en,
  output var   logic [15:0] pram_addr,
  output var   logic [15:0] pram_data,
  // Core controls
  output var   dcc_ctrl_s   ctrl,
  output var   logic [15:0] gpio_setting,
  output var   logic [10:0] instr_per_sample,
  output var   logic        conv_192k
);

  logic          rst_meta_n;
  logic          rst_n;
  logic [15:0]   if_regs [`DCC_IF_COUNT];
  logic [15:0]   aux_regs [`DCC_AUX_COUNT];
  logic [15:0]   sl_data [`DCC_SL_COUNT];
  logic [15:0]   sl_addr [`DCC_SL_COUNT];
  logic [4:0]    sl_pending;
  logic [2:0]    sl_idx;
  dcc_sl_state_e sl_state;
  dcc_sl_state_e next_sl_state;
  logic          wr_ctrl;
  logic          wr_if;
  logic          wr_gpio;
  logic          wr_aux;
  logic          wr_sld;
  logic          wr_sla;
  logic          sl_done;
  logic          trig_req;
  logic [15:0]   ctrl_wval;
  logic [15:0]   next_rdata;

  // Reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // Write decode
  always_comb begin
    wr_ctrl = cp_wr && (cp_addr == `DCC_ADDR_CORE_CTRL);
    wr_if   = cp_wr && dcc_in_range(cp_addr, `DCC_ADDR_IF_FIRST, `DCC_ADDR_IF_LAST);
    wr_gpio = cp_wr && (cp_addr == `DCC_ADDR_GPIO_SET);
    wr_aux  = cp_wr && dcc_in_range(cp_addr, `DCC_ADDR_AUX_FIRST, `DCC_ADDR_AUX_LAST);
    wr_sld  = cp_wr && (sl_state == DCC_SL_IDLE)
              && dcc_in_range(cp_addr, `DCC_ADDR_SL_DATA0, `DCC_ADDR_SL_DATA4);
    wr_sla  = cp_wr && (sl_state == DCC_SL_IDLE)
              && dcc_in_range(cp_addr, `DCC_ADDR_SL_ADDR0, `DCC_ADDR_SL_ADDR4);
    ctrl_wval = cp_wdata & `DCC_CTRL_WR_MASK;
    trig_req  = wr_ctrl && cp_wdata[`DCC_BIT_TRIGGER];
    sl_done   = (sl_state == DCC_SL_RUN) && (sl_idx == `DCC_SL_LAST_IDX);
  end

  // Control word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= dcc_ctrl_s'(`DCC_CTRL_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl <= dcc_ctrl_s'(ctrl_wval);
        if (sl_state == DCC_SL_RUN) begin
          ctrl.safeload_trigger <= 1'b1;
        end
      end
      if (sl_done && !trig_req) begin
        ctrl.safeload_trigger <= 1'b0;
      end
    end
  end

  // Interface words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `DCC_IF_COUNT; i++) begin
        if_regs[i] <= 16'h0000;
      end
    end else if (ctrl.interface_regs_host_write_en) begin
      if (wr_if) begin
        if_regs[cp_addr[2:0]] <= cp_wdata;
      end
    end else if (dsp_if_wr) begin
      if_regs[dsp_if_idx] <= dsp_if_data;
    end
  end

  // GPIO setting word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_setting <= 16'h0000;
    end else if (ctrl.gpio_setting_host_write_en) begin
      if (wr_gpio) begin
        gpio_setting <= cp_wdata;
      end
    end else begin
      gpio_setting <= gpio_pins;
    end
  end

  // Aux ADC data words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `DCC_AUX_COUNT; i++) begin
        aux_regs[i] <= 16'h0000;
      end
    end else if (ctrl.aux_adc_host_write_en) begin
      if (wr_aux) begin
        aux_regs[2'(cp_addr - `DCC_ADDR_AUX_FIRST)] <= cp_wdata;
      end
    end else begin
      for (int i = 0; i < `DCC_AUX_COUNT; i++) begin
        aux_regs[i] <= aux_adc_samples[i*16 +: 16];
      end
    end
  end

  // Safeload slots
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `DCC_SL_COUNT; i++) begin
        sl_data[i] <= 16'h0000;
        sl_addr[i] <= 16'h0000;
      end
      sl_pending <= 5'h00;
    end else begin
      if (sl_state == DCC_SL_RUN) begin
        sl_pending[sl_idx] <= 1'b0;
      end
      if (wr_sld) begin
        sl_data[3'(cp_addr - `DCC_ADDR_SL_DATA0)]    <= cp_wdata;
        sl_pending[3'(cp_addr - `DCC_ADDR_SL_DATA0)] <= 1'b1;
      end
      if (wr_sla) begin
        sl_addr[3'(cp_addr - `DCC_ADDR_SL_ADDR0)]    <= cp_wdata;
        sl_pending[3'(cp_addr - `DCC_ADDR_SL_ADDR0)] <= 1'b1;
      end
    end
  end

  // Safeload sequencer
  always_comb begin
    case (sl_state)
      DCC_SL_IDLE: next_sl_state = trig_req ? DCC_SL_RUN : DCC_SL_IDLE;
      DCC_SL_RUN:  next_sl_state = sl_done ? DCC_SL_IDLE : DCC_SL_RUN;
      default:     next_sl_state = DCC_SL_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sl_state <= DCC_SL_IDLE;
      sl_idx   <= 3'h0;
    end else begin
      sl_state <= next_sl_state;
      sl_idx   <= (sl_state == DCC_SL_RUN && !sl_done) ? 3'(sl_idx + 3'h1) : 3'h0;
    end
  end

  // Parameter RAM writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pram_wr_en <= 1'b0;
      pram_addr  <= 16'h0000;
      pram_data  <= 16'h0000;
    end else begin
      pram_wr_en <= (sl_state == DCC_SL_RUN) && sl_pending[sl_idx];
      pram_addr  <= sl_addr[sl_idx];
      pram_data  <= sl_data[sl_idx];
    end
  end

  // Rate decode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_per_sample <= `DCC_IPS_1X;
      conv_192k        <= 1'b0;
    end else begin
      case (dcc_rate_e'(ctrl.rate_select))
        DCC_RATE_1X: instr_per_sample <= `DCC_IPS_1X;
        DCC_RATE_2X: instr_per_sample <= `DCC_IPS_2X;
        DCC_RATE_4X: instr_per_sample <= `DCC_IPS_4X;
        default:     instr_per_sample <= instr_per_sample;
      endcase
      conv_192k <= (dcc_rate_e'(ctrl.rate_select) == DCC_RATE_4X);
    end
  end

  // Read mux
  always_comb begin
    next_rdata = 16'h0000;
    if (cp_addr == `DCC_ADDR_CORE_CTRL) begin
      next_rdata = ctrl & `DCC_CTRL_WR_MASK;
    end else if (dcc_in_range(cp_addr, `DCC_ADDR_IF_FIRST, `DCC_ADDR_IF_LAST)) begin
      next_rdata = if_regs[cp_addr[2:0]];
    end else if (cp_addr == `DCC_ADDR_GPIO_SET) begin
      next_rdata = gpio_setting;
    end else if (dcc_in_range(cp_addr, `DCC_ADDR_AUX_FIRST, `DCC_ADDR_AUX_LAST)) begin
      next_rdata = aux_regs[2'(cp_addr - `DCC_ADDR_AUX_FIRST)];
    end else if (dcc_in_range(cp_addr, `DCC_ADDR_SL_DATA0, `DCC_ADDR_SL_DATA4)) begin
      next_rdata = sl_data[3'(cp_addr - `DCC_ADDR_SL_DATA0)];
    end else if (dcc_in_range(cp_addr, `DCC_ADDR_SL_ADDR0, `DCC_ADDR_SL_ADDR4)) begin
      next_rdata = sl_addr[3'(cp_addr - `DCC_ADDR_SL_ADDR0)];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cp_rdata    <= 16'h0000;
      cp_rd_valid <= 1'b0;
    end else begin
      cp_rd_valid <= cp_rd;
      if (cp_rd) begin
        cp_rdata <= next_rdata;
      end
    end
  end

endmodule

`default_nettype wire

/* File: hdl/dcc_pkg.sv */
// Purpose: Types and shared decode of the core control block
// Assumes: Constants come from the guarded header
// Notes:   Field layout of the control word as a packed struct
`include "dcc_consts.svh"

package dcc_pkg;

  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic [1:0] gpio_debounce_sel;
    logic [2:0] rsvd_mid;
    logic       aux_adc_host_write_en;
    logic       gpio_setting_host_write_en;
    logic       interface_regs_host_write_en;
    logic       safeload_trigger;
    logic       adc_unmute;
    logic       dac_unmute;
    logic       core_clear_n;
    logic [1:0] rate_select;
  } dcc_ctrl_s;

  typedef enum logic [1:0] {
    DCC_RATE_1X  = 2'b00,
    DCC_RATE_2X  = 2'b01,
    DCC_RATE_4X  = 2'b10,
    DCC_RATE_RSV = 2'b11
  } dcc_rate_e;

  typedef enum logic [0:0] {
    DCC_SL_IDLE = 1'b0,
    DCC_SL_RUN  = 1'b1
  } dcc_sl_state_e;

  typedef struct packed {
    logic        wr_en;
    logic [15:0] addr;
    logic [15:0] data;
  } dcc_port_wr_s;

  // Address window check
  function automatic logic dcc_in_range(input logic [15:0] a,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    dcc_in_range = (a >= lo) && (a <= hi);
  endfunction

endpackage

/* File: testbench/dcc_core_ctrl_properties.sv */
// Purpose: Port checks of the core control block
// Assumes: Bound to the top module
// Notes:   One clock domain
`timescale 1ns/1ps
`default_nettype none
`include "dcc_consts.svh"
module dcc_core_ctrl_properties
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Control port
  input wire logic        cp_wr,
  input wire logic [15:0] cp_addr,
  input wire logic [15:0] cp_wdata,
  // Pins and outputs
  input wire logic [15:0] gpio_pins,
  input wire logic [15:0] gpio_setting,
  input wire logic        pram_wr_en,
  input wire dcc_ctrl_s   ctrl,
  input wire logic [10:0] instr_per_sample,
  input wire logic        conv_192k
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_run;
    ctrl.safeload_trigger [*5];
  endsequence
  a_reset_zero: assert property ($rose(resetn) |-> ctrl == `DCC_CTRL_RESET)
    else $error("reset value");
  a_ctrl_write: assert property (cp_wr && cp_addr == `DCC_ADDR_CORE_CTRL &&
    !ctrl.safeload_trigger |=> ctrl == ($past(cp_wdata) & `DCC_CTRL_WR_MASK))
    else $error("control write");
  a_trigger_clears: assert property ($rose(ctrl.safeload_trigger) |-> s_run ##1
    !ctrl.safeload_trigger) else $error("trigger clear");
  a_pram_in_run: assert property (pram_wr_en |->
    ctrl.safeload_trigger || $past(ctrl.safeload_trigger)) else $error("pram outside run");
  a_gpio_follow: assert property (!ctrl.gpio_setting_host_write_en && !cp_wr |=>
    gpio_setting == $past(gpio_pins)) else $error("gpio follow");
  a_gpio_hold: assert property (ctrl.gpio_setting_host_write_en && !cp_wr |=>
    $stable(gpio_setting)) else $error("gpio hold");
  a_rate_decode: assert property (1'b1 |=> instr_per_sample ==
    ($past(ctrl.rate_select) == 2'b11 ? $past(instr_per_sample) :
    (11'h400 >> $past(ctrl.rate_select)))) else $error("rate decode");
  a_conv_rate: assert property (1'b1 |=>
    conv_192k == ($past(ctrl.rate_select) == 2'b10)) else $error("converter rate");
endmodule
bind dcc_core_ctrl dcc_core_ctrl_properties i_props (
  .clk(clk), .resetn(resetn), .cp_wr(cp_wr), .cp_addr(cp_addr), .cp_wdata(cp_wdata),
  .gpio_pins(gpio_pins), .gpio_setting(gpio_setting), .pram_wr_en(pram_wr_en),
  .ctrl(ctrl), .instr_per_sample(instr_per_sample), .conv_192k(conv_192k)
);
`default_nettype wire

/* File: testbench/dcc_core_ctrl_tb.sv */
// Purpose: Self-checking bench of the core control block
// Assumes: Host model drives the control port
// Notes:   Random data from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "dcc_consts.svh"
module dcc_core_ctrl_tb
  import dcc_pkg::*;
();
  logic        clk, resetn, cp_wr, cp_rd, cp_rd_valid, dsp_if_wr, pram_wr_en, conv_192k;
  logic [15:0] cp_addr, cp_wdata, cp_rdata, dsp_if_data, gpio_pins, gpio_setting, v, w;
  logic [15:0] pram_addr, pram_data;
  logic [2:0]  dsp_if_idx;
  logic [63:0] aux_adc_samples;
  logic [10:0] instr_per_sample, ips_e;
  dcc_ctrl_s   ctrl;
  logic [31:0] q[$], e[$];
  int          err_count, comparisons;
  dcc_host_model i_host (.clk(clk), .cp_wr(cp_wr), .cp_rd(cp_rd), .cp_addr(cp_addr),
    .cp_wdata(cp_wdata), .cp_rdata(cp_rdata), .cp_rd_valid(cp_rd_valid));
  dcc_core_ctrl i_dut (.clk(clk), .resetn(resetn), .cp_wr(cp_wr), .cp_rd(cp_rd),
    .cp_addr(cp_addr), .cp_wdata(cp_wdata), .cp_rdata(cp_rdata), .cp_rd_valid(cp_rd_valid),
    .dsp_if_wr(dsp_if_wr), .dsp_if_idx(dsp_if_idx), .dsp_if_data(dsp_if_data),
    .gpio_pins(gpio_pins), .aux_adc_samples(aux_adc_samples), .pram_wr_en(pram_wr_en),
    .pram_addr(pram_addr), .pram_data(pram_data), .ctrl(ctrl), .gpio_setting(gpio_setting),
    .instr_per_sample(instr_per_sample), .conv_192k(conv_192k));
  function automatic logic [10:0] ips_of(input logic [1:0] r, input logic [10:0] p);
    ips_of = (r == 2'b11) ? p : (11'h400 >> r);
  endfunction
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] s);
    comparisons++;
    if (s !== x) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #200000;
    err_count++;
    wrap_up();
  end
  always @(posedge clk) if (pram_wr_en === 1'b1) q.push_back({pram_addr, pram_data});
  initial begin
    resetn = 1'b0;
    dsp_if_wr = 1'b0;
    dsp_if_idx = 3'h3;
    dsp_if_data = 16'h0000;
    gpio_pins = 16'h0000;
    aux_adc_samples = 64'h0;
    void'($urandom(32'hf23c));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("ctrl", 16'h0000, ctrl);
    ips_e = 11'h400;
    for (int r = 0; r < 4; r++) begin
      v = (16'($urandom) & 16'hFE1C) | 16'(r);
      i_host.wr(`DCC_ADDR_CORE_CTRL, v);
      ips_e = ips_of(2'(r), ips_e);
      @(posedge clk);
      #1;
      chk("ips", {5'h00, ips_e}, {5'h00, instr_per_sample});
      chk("conv", {15'h0000, r == 2}, {15'h0000, conv_192k});
      i_host.rd(`DCC_ADDR_CORE_CTRL, w);
      chk("ctrl rd", v & `DCC_CTRL_WR_MASK, w);
    end
    i_host.rd(16'h0900, w);
    chk("unmapped", 16'h0000, w);
    gpio_pins <= 16'($urandom);
    i_host.wr(`DCC_ADDR_GPIO_SET, 16'h5A5A);
    @(posedge clk);
    #1;
    chk("gpio follow", gpio_pins, gpio_setting);
    i_host.wr(`DCC_ADDR_CORE_CTRL, 16'h01DC);
    v = 16'($urandom);
    dsp_if_wr <= 1'b1;
    dsp_if_data <= ~v;
    i_host.wr(`DCC_ADDR_GPIO_SET, v);
    gpio_pins <= ~v;
    aux_adc_samples <= {$urandom, $urandom};
    i_host.wr(16'h0803, v);
    i_host.wr(16'h080A, v);
    chk("gpio ovr", v, gpio_setting);
    i_host.rd(16'h0803, w);
    chk("if ovr", v, w);
    i_host.rd(16'h080A, w);
    chk("aux ovr", v, w);
    i_host.wr(`DCC_ADDR_CORE_CTRL, 16'h001C);
    @(posedge clk);
    dsp_if_wr <= 1'b0;
    i_host.wr(16'h0803, v);
    i_host.rd(16'h0803, w);
    chk("if dsp", ~v, w);
    i_host.rd(16'h080A, w);
    chk("aux pins", aux_adc_samples[31:16], w);
    for (int k = 0; k < 5; k += 4) begin
      v = 16'($urandom);
      w = 16'($urandom);
      i_host.wr(`DCC_ADDR_SL_ADDR0 + 16'(k), v);
      i_host.wr(`DCC_ADDR_SL_DATA0 + 16'(k), w);
      e.push_back({v, w});
    end
    for (int n = 0; n < 2; n++) begin
      q.delete();
      i_host.safeload();
      repeat (3) @(posedge clk);
      #1;
      chk("trigger", 16'h0000, {15'h0000, ctrl.safeload_trigger});
      chk("pram count", 16'(e.size()), 16'(q.size()));
      for (int i = 0; i < e.size() && i < q.size(); i++) begin
        chk("pram addr", e[i][31:16], q[i][31:16]);
        chk("pram data", e[i][15:0], q[i][15:0]);
      end
      e.delete();
    end
    wrap_up();
  end
endmodule
`default_nettype wire

/* File: testbench/dcc_host_model.sv */
// Purpose: Host on the control port
// Assumes: Requests change just after the rising edge
// Notes:   Idle address and data show inverted values
`timescale 1ns/1ps
`default_nettype none
`include "dcc_consts.svh"
module dcc_host_model
  import dcc_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Control port
  output var  logic        cp_wr = 1'b0,
  output var  logic        cp_rd = 1'b0,
  output var  logic [15:0] cp_addr = 16'h0000,
  output var  logic [15:0] cp_wdata = 16'h0000,
  input  wire logic [15:0] cp_rdata,
  input  wire logic        cp_rd_valid
);
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    cp_wr <= 1'b1;
    cp_addr <= a;
    cp_wdata <= d;
    @(posedge clk);
    cp_wr <= 1'b0;
    cp_addr <= ~a;
    cp_wdata <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    cp_rd <= 1'b1;
    cp_addr <= a;
    @(posedge clk);
    cp_rd <= 1'b0;
    cp_addr <= ~a;
    @(posedge clk);
    d = cp_rd_valid ? cp_rdata : 16'hxxxx;
  endtask
  task automatic safeload();
    logic [15:0] d;
    wr(`DCC_ADDR_CORE_CTRL, 16'h0024);
    for (int i = 0; i < 20; i++) begin
      rd(`DCC_ADDR_CORE_CTRL, d);
      if (d[`DCC_BIT_TRIGGER] === 1'b0) break;
    end
  endtask
endmodule
`default_nettype wire
